// ==== sim/alarm_link_assertions.sv ====
// concurrent checks on the sensor link and alarm wire
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_link_assertions
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // link
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic alarm_pin_n,
    // sensor side
    input wire logic [9:0] junction_temp_i,
    input wire logic [6:0] led_current_i,
    input wire logic [6:0] led_current_setting_i,
    input wire logic powerup_busy_i,
    input wire logic shutdown_o,
    input wire logic [9:0] trip_threshold_o
);
    // ==========
    // live causes; masks are internal, so only the pin-low direction is checked
    logic live;
    assign live = powerup_busy_i || shutdown_o || (junction_temp_i > `SHDN_LIMIT_C)
        || (junction_temp_i > trip_threshold_o)
        || ({3'h0, led_current_i, 3'h0} > 13'(led_current_setting_i) * 13'd7);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    property p_ack_once; ack |=> !ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_due; req && !ack && !powerup_busy_i |=> ack; endproperty
    a_ack_due: assert property (p_ack_due) else $error("ack missing");
    property p_busy_quiet; powerup_busy_i |=> !ack; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("ack in power-up");
    property p_pup_pin; powerup_busy_i |-> !alarm_pin_n; endproperty
    a_pup_pin: assert property (p_pup_pin) else $error("pin free in power-up");
    property p_pin_cause; !alarm_pin_n |-> live || $past(live); endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin low, no cause");
    property p_thr;
        ack && we && addr == `ADDR_TRIP
            |=> trip_threshold_o == 10'd200 - 10'd9 * 10'(3'($past(wdata)));
    endproperty
    a_thr: assert property (p_thr) else $error("bad threshold");
    property p_sd_hold; shutdown_o |=> shutdown_o; endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("shutdown dropped");
    property p_sd_set; junction_temp_i > 10'd165 |-> ##[0:2] shutdown_o; endproperty
    a_sd_set: assert property (p_sd_set) else $error("no shutdown");
    property p_resv; ack && !we && addr == `ADDR_ALARM_MASK_STATUS |-> !rdata[3]; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_unmapped; ack && !we && addr == 16'h088C |-> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
endmodule : alarm_link_assertions

// ==== sim/encoder_alarm_and_enable_regs_tb.sv ====
// bench: host and sensor ends joined over the link
`timescale 1ns/1ps
`include "alarm_regs.svh"
module encoder_alarm_and_enable_regs_tb;
    // ==========
    // signals and instances
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [9:0] temp = 10'd25, thr;
    logic [6:0] led = 7'h00, setting = 7'h40;
    logic busy = 1'b1, amp_on, interp_off, index_off, maint, sd;
    int err_total = 0, compares = 0;
    always #2.5 clock_i = ~clock_i;
    alarm_link_if link ();
    alarm_host i_alarm_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link(link.host));
    alarm_device i_alarm_device (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link.dev),
        .junction_temp_i(temp), .led_current_i(led), .led_current_setting_i(setting),
        .powerup_busy_i(busy), .index_amp_on_o(amp_on), .interp_comp_off_o(interp_off),
        .index_comp_off_o(index_off), .maintenance_out_o(maint), .shutdown_o(sd),
        .trip_threshold_o(thr));
    alarm_link_assertions i_alarm_link_assertions (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata), .alarm_pin_n(link.alarm_pin_n), .junction_temp_i(temp),
        .led_current_i(led), .led_current_setting_i(setting), .powerup_busy_i(busy),
        .shutdown_o(sd), .trip_threshold_o(thr));
    // ==========
    // tasks and expectations
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask : apb
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] rd);
        logic [31:0] r;
        logic e;
        apb(1'b1, `APB_CMD_OFF, {7'h00, w, a, d}, r, e);
        do apb(1'b0, `APB_STAT_OFF, 32'h0, r, e); while (r[1:0] !== 2'b10);
        apb(1'b0, `APB_RDATA_OFF, 32'h0, r, e);
        rd = r[7:0];
    endtask : acc
    function automatic logic [7:0] exp_alarm_mask_status(input logic l, input logic t, input logic [2:0] m);
        return {1'b0, l, t, 2'b00, m};
    endfunction : exp_alarm_mask_status
    function automatic logic [9:0] exp_thr(input logic [2:0] c);
        return `TRIP_BASE_C - `TRIP_STEP_C * {7'h00, c};
    endfunction : exp_thr
    function automatic logic exp_pin(input logic l, input logic t, input logic [2:0] m);
        return !((m[2] && l) || (m[1] && t));
    endfunction : exp_pin
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // ==========
    // main sequence and watchdog
    initial
    begin
        logic [7:0] rd, tv;
        logic [31:0] r;
        logic e, l, t;
        logic [2:0] m, code;
        logic [6:0] s, lim;
        logic [15:0] ra[5] = '{`ADDR_TRIP, `ADDR_AMPE, `ADDR_CMPD, `ADDR_AUX, 16'h088C};
        logic [7:0] rv[5] = '{`RST_TRIP, `RST_AMPE, `RST_CMPD, `RST_AUX, 8'h00};
        void'($urandom(9515));
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        chk("pin_boot", link.alarm_pin_n, 1'b0);
        busy <= 1'b0;
        acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
        chk("alarm_mask_status_pup", rd, 8'h80);
        acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
        chk("alarm_mask_status_clr", rd, 8'h00);
        foreach (ra[i])
        begin
            acc(1'b0, ra[i], 8'h00, rd);
            chk("rst_val", rd, rv[i]);
        end
        chk("gate_rst", {amp_on, interp_off, index_off, maint}, 4'b1000);
        chk("thr_rst", thr, exp_thr(3'h0));
        acc(1'b1, `ADDR_AMPE, 8'hFB, rd);
        acc(1'b1, `ADDR_CMPD, 8'h30, rd);
        acc(1'b1, `ADDR_AUX, 8'h31, rd);
        chk("gate_set", {amp_on, interp_off, index_off, maint}, 4'b0111);
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk("slverr", e, 1'b1);
        acc(1'b1, `ADDR_TRIP, 8'h03, rd);
        chk("thr_c3", thr, exp_thr(3'h3));
        tv = 8'h03;
        for (int i = 0; i < 8; i++)
        begin
            // codes 4..7 keep the alarm temperature below shutdown
            code = (i == 0) ? 3'h4 : (i == 1) ? 3'h7 : {1'b1, 2'($urandom)};
            m = 3'($urandom);
            l = 1'($urandom);
            t = 1'($urandom);
            acc(1'b0, `ADDR_TRIP, 8'h00, rd);
            chk("trip_rb", rd, tv);
            tv = {rd[7:3], code};
            acc(1'b1, `ADDR_TRIP, tv, rd);
            chk("thr", thr, exp_thr(code));
            acc(1'b1, `ADDR_ALARM_MASK_STATUS, {5'h1F, m}, rd);
            s = 7'($urandom);
            lim = 7'((`LED_RATIO_C * {3'h0, s}) >> 3);
            setting <= s;
            temp <= exp_thr(code) + 10'(t);
            led <= l ? lim + 7'h01 : lim;
            acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
            chk("alarm_mask_status_live", rd, exp_alarm_mask_status(l, t, m));
            chk("pin_live", link.alarm_pin_n, exp_pin(l, t, m));
            apb(1'b0, `APB_ALARM_MASK_STATUS_OFF, 32'h0, r, e);
            chk("pin_sts", r, {31'h0, !exp_pin(l, t, m)});
            temp <= 10'd25;
            led <= 7'h00;
            acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
            chk("alarm_mask_status_held", rd, exp_alarm_mask_status(l, t, m));
            chk("pin_free", link.alarm_pin_n, 1'b1);
            apb(1'b0, `APB_ALARM_MASK_STATUS_OFF, 32'h0, r, e);
            chk("pin_sts_free", r, 32'h0);
        end
        acc(1'b1, `ADDR_ALARM_MASK_STATUS, 8'h01, rd);
        temp <= 10'd166;
        acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
        chk("sd_live", rd, 8'h31);
        temp <= 10'd25;
        acc(1'b0, `ADDR_ALARM_MASK_STATUS, 8'h00, rd);
        chk("sd_held", {rd, sd, link.alarm_pin_n}, {8'h31, 2'b10});
        apb(1'b0, `APB_ALARM_MASK_STATUS_OFF, 32'h0, r, e);
        chk("pin_sts_sd", r, 32'h1);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        stop_test();
    end
endmodule : encoder_alarm_and_enable_regs_tb

// ==== verilog/alarm_device.sv ====
// sensor-side alarm, mask/status and power-gating register block
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_device
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // register link and alarm pin
    alarm_link_if.dev link,
    // analog-side indications, already synchronous
    input wire logic [9:0] junction_temp_i,
    input wire logic [6:0] led_current_i,
    input wire logic [6:0] led_current_setting_i,
    input wire logic powerup_busy_i,
    // power-gating controls, shutdown and trip threshold
    output logic index_amp_on_o,
    output logic interp_comp_off_o,
    output logic index_comp_off_o,
    output logic maintenance_out_o,
    output logic shutdown_o,
    output logic [9:0] trip_threshold_o
);
    // =====================================================
    // state and wiring
    typedef struct packed {
        logic [7:0] trip;
        logic [7:0] mask;
        logic [7:0] ampe;
        logic [7:0] cmpd;
        logic [7:0] aux;
        logic shut_hold;
        logic [9:0] thr;
        logic maint;
        logic ack;
        logic [7:0] rdata;
    } st_type;
    st_type s_r, s_nxt;
    logic [9:0] thr;
    logic cond_sd, cond_ta, cond_led;
    logic hot;
    logic [9:0] led_scaled, led_limit;
    logic wr_acc;
    logic pull_pup, pull_sd, pull_ta, pull_led;
    logic [3:0] stat;
    logic rd_alarm_mask_status;
    logic [7:0] alarm_mask_status_view;
    logic acc;
    // =====================================================
    // conditions
    // threshold kept 10 bits so code 7 cannot wrap
    assign thr = `TRIP_BASE_C - `TRIP_STEP_C * {7'h00, s_r.trip[`TRIP_CODE_MSB:0]};
    assign hot = junction_temp_i > `SHDN_LIMIT_C;
    assign cond_sd = s_r.shut_hold | hot;
    // registered threshold: pin and threshold output see one value
    assign cond_ta = junction_temp_i > s_r.thr;
    // =====================================================
    // led loop check
    // 8*i > 7*setting avoids a divider
    assign led_scaled = {led_current_i, 3'h0};
    assign led_limit = `LED_RATIO_C * {3'h0, led_current_setting_i};
    assign cond_led = led_scaled > led_limit;
    // =====================================================
    // access decode
    assign acc = link.req & ~s_r.ack & ~powerup_busy_i;
    assign wr_acc = acc & link.we;
    assign rd_alarm_mask_status = acc & ~link.we & (link.addr == `ADDR_ALARM_MASK_STATUS);
    // =====================================================
    // status flags
    // set beats the read clear so a live fault is never lost
    sticky_flag u_pup
    (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(powerup_busy_i),
        .clr_i(rd_alarm_mask_status),
        .flag_o(stat[3])
    );
    sticky_flag u_led
    (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(cond_led),
        .clr_i(rd_alarm_mask_status),
        .flag_o(stat[2])
    );
    sticky_flag u_ta
    (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(cond_ta),
        .clr_i(rd_alarm_mask_status),
        .flag_o(stat[1])
    );
    sticky_flag u_sd
    (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .set_i(cond_sd),
        .clr_i(rd_alarm_mask_status),
        .flag_o(stat[0])
    );
    always_comb
    begin
        alarm_mask_status_view = 8'h00; // reserved bit 3 reads zero
        alarm_mask_status_view[`B_PUP] = stat[3];
        alarm_mask_status_view[`B_LED] = stat[2];
        alarm_mask_status_view[`B_TA] = stat[1];
        alarm_mask_status_view[`B_SD] = stat[0];
        alarm_mask_status_view[`B_MLED] = s_r.mask[`B_MLED];
        alarm_mask_status_view[`B_MTA] = s_r.mask[`B_MTA];
        alarm_mask_status_view[`B_MSD] = s_r.mask[`B_MSD];
    end
    // =====================================================
    // register access; accesses during power-up are ignored and not acked
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = acc;
        s_nxt.shut_hold = cond_sd;
        s_nxt.thr = thr;
        s_nxt.maint = (s_r.aux[`PM_MSB:`PM_LSB] == `PM_ON);
        // unmapped writes change nothing; unmapped reads return zero
        if (wr_acc)
        begin
            unique case (link.addr)
                `ADDR_TRIP: s_nxt.trip = link.wdata;
                `ADDR_ALARM_MASK_STATUS: s_nxt.mask = link.wdata & `MASK_BITS;
                `ADDR_AMPE: s_nxt.ampe = link.wdata;
                `ADDR_CMPD: s_nxt.cmpd = link.wdata;
                `ADDR_AUX: s_nxt.aux = link.wdata;
                default: s_nxt.ampe = s_r.ampe;
            endcase
        end
        if (acc)
        begin
            unique case (link.addr)
                `ADDR_TRIP: s_nxt.rdata = s_r.trip;
                `ADDR_ALARM_MASK_STATUS: s_nxt.rdata = alarm_mask_status_view;
                `ADDR_AMPE: s_nxt.rdata = s_r.ampe;
                `ADDR_CMPD: s_nxt.rdata = s_r.cmpd;
                `ADDR_AUX: s_nxt.rdata = s_r.aux;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end
    // =====================================================
    // state register
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_r.trip <= `RST_TRIP;
            s_r.mask <= `RST_ALARM_MASK_STATUS;
            s_r.ampe <= `RST_AMPE;
            s_r.cmpd <= `RST_CMPD;
            s_r.aux <= `RST_AUX;
            s_r.shut_hold <= 1'b0;
            // threshold of the reset trip code
            s_r.thr <= `TRIP_BASE_C;
            s_r.maint <= 1'b0;
            s_r.ack <= 1'b0;
            s_r.rdata <= 8'h00;
        end
        else
            s_r <= s_nxt;
    end
    // =====================================================
    // outputs
    assign link.ack = s_r.ack;
    assign link.rdata = s_r.rdata;
    assign link.pin_o = 1'b0;
    // pin is live, not latched, except the shutdown cause held by shut_hold: status may stay set after release
    assign pull_pup = powerup_busy_i;
    assign pull_sd = cond_sd & s_r.mask[`B_MSD];
    assign pull_ta = cond_ta & s_r.mask[`B_MTA];
    assign pull_led = cond_led & s_r.mask[`B_MLED];
    assign link.pin_oe_n = ~(pull_pup | pull_sd | pull_ta | pull_led);
    // gating bits drive the analog stages straight from the registers
    assign index_amp_on_o = s_r.ampe[`B_IDX_AMP];
    assign interp_comp_off_o = s_r.cmpd[`B_INTERP];
    assign index_comp_off_o = s_r.cmpd[`B_IDX_COMP];
    assign maintenance_out_o = s_r.maint;
    assign shutdown_o = s_r.shut_hold;
    assign trip_threshold_o = s_r.thr;
endmodule : alarm_device

// ==== verilog/alarm_host.sv ====
// host end: APB-programmed controller that accesses the sensor registers
`timescale 1ns/1ps
`include "alarm_regs.svh"
module alarm_host
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // link to device
    alarm_link_if.host link
);
    typedef struct packed {
        alarm_pkg::ctl_state_type st;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic pin_s1;
        logic pin_s2;
    } st_type;
    st_type s_r, s_nxt;
    logic wr, known;
    assign wr = psel_i & penable_i & pwrite_i;
    assign known = (paddr_i == `APB_ALARM_MASK_STATUS_OFF) | (paddr_i == `APB_CMD_OFF)
        | (paddr_i == `APB_STAT_OFF) | (paddr_i == `APB_RDATA_OFF);
    // =====================================================
    // command engine; software obeys reserved-field and gating rules
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pin_s1 = link.alarm_pin_n;
        s_nxt.pin_s2 = s_r.pin_s1;
        unique case (s_r.st)
            alarm_pkg::CTL_IDLE:
            begin
                // cmd word: [24] write, [23:8] address, [7:0] data
                if (wr && paddr_i == `APB_CMD_OFF)
                begin
                    s_nxt.we = pwdata_i[`CMD_WE_BIT];
                    s_nxt.addr = pwdata_i[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                    s_nxt.wdata = pwdata_i[`CMD_DATA_MSB:0];
                    s_nxt.done = 1'b0;
                    s_nxt.st = alarm_pkg::CTL_REQ;
                end
            end
            alarm_pkg::CTL_REQ:
            begin
                if (link.ack)
                begin
                    s_nxt.rdata = link.rdata;
                    s_nxt.st = alarm_pkg::CTL_DONE;
                end
            end
            alarm_pkg::CTL_DONE:
            begin
                s_nxt.done = 1'b1;
                s_nxt.st = alarm_pkg::CTL_IDLE;
            end
            default: s_nxt.st = alarm_pkg::CTL_IDLE;
        endcase
    end
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            s_r.st <= alarm_pkg::CTL_IDLE;
            s_r.we <= 1'b0;
            s_r.addr <= 16'h0000;
            s_r.wdata <= 8'h00;
            s_r.rdata <= 8'h00;
            s_r.done <= 1'b0;
            s_r.pin_s1 <= 1'b1;
            s_r.pin_s2 <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end
    // =====================================================
    // outputs
    assign link.req = (s_r.st == alarm_pkg::CTL_REQ);
    assign link.we = s_r.we;
    assign link.addr = s_r.addr;
    // codes 01/10 in the maintenance field are not filtered; software must avoid them
    assign link.wdata = s_r.wdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~known;
    always_comb
    begin
        prdata_o = 32'h00000000;
        if (paddr_i == `APB_ALARM_MASK_STATUS_OFF)
            prdata_o = {31'h00000000, ~s_r.pin_s2};
        else if (paddr_i == `APB_STAT_OFF)
            prdata_o = {30'h00000000, s_r.done, s_r.st != alarm_pkg::CTL_IDLE};
        else if (paddr_i == `APB_RDATA_OFF)
            prdata_o = {24'h000000, s_r.rdata};
    end
endmodule : alarm_host

// ==== verilog/alarm_link_if.sv ====
// register link and open-drain alarm wire between host and sensor block
`timescale 1ns/1ps
interface alarm_link_if;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic pin_o;
    logic pin_oe_n;
    wire alarm_pin_n = pin_oe_n ? 1'b1 : pin_o;
    modport dev (input req, we, addr, wdata, output ack, rdata, pin_o, pin_oe_n);
    modport host (output req, we, addr, wdata, input ack, rdata, alarm_pin_n);
endinterface : alarm_link_if

// ==== verilog/alarm_pkg.sv ====
// controller state type used by the alarm host
package alarm_pkg;
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_REQ = 2'b01,
        CTL_DONE = 2'b10
    } ctl_state_type;
endpackage : alarm_pkg

// ==== verilog/alarm_regs.svh ====
// register offsets, field positions and reset values of the alarm and enable block
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH
`define ADDR_TRIP 16'h0888
`define ADDR_ALARM_MASK_STATUS 16'h0889
`define ADDR_AMPE 16'h088A
`define ADDR_CMPD 16'h088B
`define ADDR_AUX 16'h088D
`define RST_TRIP 8'h00
`define RST_ALARM_MASK_STATUS 8'h00
`define RST_AMPE 8'hFF
`define RST_CMPD 8'h00
`define RST_AUX 8'h01
`define TRIP_CODE_MSB 2
`define TRIP_BASE_C 10'd200
`define TRIP_STEP_C 10'd9
`define SHDN_LIMIT_C 10'd165
`define B_PUP 7
`define B_LED 6
`define B_TA 5
`define B_SD 4
`define B_MLED 2
`define B_MTA 1
`define B_MSD 0
`define B_IDX_AMP 2
`define B_IDX_COMP 5
`define B_INTERP 4
`define PM_MSB 5
`define PM_LSB 4
`define PM_ON 2'h3
`define MASK_BITS 8'h07
`define LED_RATIO_C 10'd7
`define CMD_WE_BIT 24
`define CMD_ADDR_MSB 23
`define CMD_ADDR_LSB 8
`define CMD_DATA_MSB 7
`define APB_ALARM_MASK_STATUS_OFF 12'h000
`define APB_CMD_OFF 12'h004
`define APB_STAT_OFF 12'h008
`define APB_RDATA_OFF 12'h00C
`endif

// ==== verilog/sticky_flag.sv ====
// one latched status bit: set wins over clear-on-read
`timescale 1ns/1ps
module sticky_flag
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // control
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    typedef struct packed { logic f_r; } st_type;
    st_type s_r, s_nxt;
    always_comb
    begin
        s_nxt = s_r;
        if (set_i)
            s_nxt.f_r = 1'b1;
        else if (clr_i)
            s_nxt.f_r = 1'b0;
    end
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign flag_o = s_r.f_r;
endmodule : sticky_flag
